// file: logic/ppc_pkg.sv
// Purpose: constants for the port phy control register bank
// Assumes: 16-bit registers reached at their printed byte offsets
// Notes:   field positions, plus the mode and lamp reserved-bit reset values, live here
package ppc_pkg;
    localparam logic [11:0] OFS_LAMP   = 12'h06c;
    localparam logic [11:0] OFS_DIAG   = 12'h07c;
    localparam logic [11:0] OFS_MODE   = 12'h07e;
    localparam logic [11:0] OFS_SPEC   = 12'h066;
    localparam logic [11:0] OFS_BASIC  = 12'h05c;
    localparam logic [11:0] OFS_ADV    = 12'h054;
    // lamp control fields
    localparam int LAMP_HI = 14;
    localparam int LAMP_LO = 12;
    localparam logic [11:0] LAMP_RSV_RST = 12'h000;
    // diagnostic fields
    localparam int DG_SHORT = 15;
    localparam int DG_RES_HI = 14;
    localparam int DG_RES_LO = 13;
    localparam int DG_RUN = 12;
    localparam int DG_FLINK = 11;
    localparam int DG_RSV = 10;
    localparam int DG_NLOOP = 9;
    localparam int DG_CNT_HI = 8;
    // mode control fields
    localparam int MD_RSV = 15;
    localparam int MD_TXDIS = 14;
    localparam int MD_RESTART = 13;
    localparam int MD_NOFEF = 12;
    localparam int MD_PDN = 11;
    localparam int MD_NOAMDIX = 10;
    localparam int MD_FMDIX = 9;
    localparam int MD_FLOOP = 8;
    localparam int MD_ANEN = 7;
    localparam int MD_SPD = 6;
    localparam int MD_DPX = 5;
    localparam logic [15:0] MODE_RST = 16'h00ff;
    // mirror positions in the other phy registers, plus the advert selector value and the failed result code
    localparam int SP_FLINK = 3;
    localparam int SP_EEE = 2;
    localparam int SP_NLOOP = 1;
    localparam int SP_RSV0 = 0;
    localparam int AD_PAUSE = 10;
    localparam int AD_100F = 8;
    localparam int AD_100H = 7;
    localparam int AD_10F = 6;
    localparam int AD_10H = 5;
    localparam int AD_RSV9 = 9;
    localparam logic [4:0] AD_SELECTOR = 5'h01;
    localparam int BC_LOOP = 14;
    localparam int BC_SPD = 13;
    localparam int BC_ANEN = 12;
    localparam int BC_PDN = 11;
    localparam int BC_RESTART = 9;
    localparam int BC_DPX = 8;
    localparam int BC_FMDIX = 4;
    localparam int BC_NOAMDIX = 3;
    localparam int BC_NOFEF = 2;
    localparam int BC_TXDIS = 1;
    localparam logic [1:0] RES_FAIL = 2'h3;
endpackage

// file: logic/ppc_regs.sv
// Purpose: port phy control and status register bank
// Assumes: one 16-bit host port, one clock, phy core reports test and negotiation results
// Notes:   mirrored bits share one flip-flop; all outputs registered
//
// What this block does
// - lamp field 14:12: top bit 0 normal, else 100 off, 101 lamp0, 110 lamp1, 111 both
// - diagnostic result bits 14:13: 00 normal, 01 open, 10 short, 11 failed
// - writing 1 to bit 12 starts diagnostic; device clears it when done
// - read-only bit 15 flags a short closer than ten meters
// - read-only bits 8:0 give fault distance, about 0.4 m per count
// - diagnostic bit 11 forces link pass; zero gives normal link detection
// - diagnostic bit 9 loops receive pair back out on transmit pair
// - mode bit 14 disables the port transmitter
// - mode bit 13 restarts negotiation and clears itself
// - mode bit 12 disables far-end-fault detection, fiber mode only
// - mode bit 11 powers down the phy, registers unchanged
// - mode bit 10 disables automatic crossover
// - with crossover disabled, mode bit 9 forces crossed wiring
// - mode bit 8 loops host frames back at the phy media layer
// - mode bit 7 enables negotiation, resets 1; else bit 5 decides duplex
// - speed bit 6, obeyed with negotiation on or off: 1 is 100 Mbps, 0 is 10 Mbps
// - forced duplex bit 5; failed negotiation always gives half duplex
// - mode bits 4:0 advertise pause, 100F, 100H, 10F, 10H; all reset 1
`timescale 1ns/1ps
`default_nettype none
module ppc_regs (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        diag_done,
    input  wire logic [1:0]  diag_result,
    input  wire logic        diag_short_near,
    input  wire logic [8:0]  diag_fault_count,
    input  wire logic        neg_done,
    input  wire logic        neg_ok,
    input  wire logic        link_pin,
    input  wire logic        neg_restart_ack,
    output logic             port_lamp_0,
    output logic             port_lamp_1,
    output logic             lamp_override,
    output logic             diag_start,
    output logic             force_link,
    output logic             near_loop,
    output logic             tx_disable,
    output logic             neg_restart,
    output logic             fef_disable,
    output logic             power_down,
    output logic             mdix_auto,
    output logic             mdix_force,
    output logic             far_loop,
    output logic             neg_enable,
    output logic             speed_100,
    output logic             full_duplex,
    output logic [4:0]       advert,
    output logic             link_up
);
    // storage
    logic [2:0]  lamp_q, lamp_d;
    logic [11:0] lamp_rsv_q, lamp_rsv_d;
    logic        run_q, run_d, flink_q, flink_d, drsv_q, drsv_d, nloop_q, nloop_d;
    logic        short_q, short_d;
    logic [1:0]  res_q, res_d;
    logic [8:0]  cnt_q, cnt_d;
    logic [15:0] mode_q, mode_d;
    logic        eee_q, eee_d, sp0_q, sp0_d, ad9_q, ad9_d;
    logic [2:0]  lnk_sync_q;
    logic        lnk_level_q, lnk_level_d;
    logic        wr_lamp, wr_diag, wr_mode, wr_spec, wr_basic, wr_adv;
    logic        start_req;
    logic [15:0] rd_d, rd_mux;
    logic        lamp0_d, lamp1_d, link_d, dpx_d;

    // address decode
    always_comb begin
        wr_lamp  = reg_wr && (reg_addr == ppc_pkg::OFS_LAMP);
        wr_diag  = reg_wr && (reg_addr == ppc_pkg::OFS_DIAG);
        wr_mode  = reg_wr && (reg_addr == ppc_pkg::OFS_MODE);
        wr_spec  = reg_wr && (reg_addr == ppc_pkg::OFS_SPEC);
        wr_basic = reg_wr && (reg_addr == ppc_pkg::OFS_BASIC);
        wr_adv   = reg_wr && (reg_addr == ppc_pkg::OFS_ADV);
        start_req = wr_diag && reg_wdata[ppc_pkg::DG_RUN];
    end

    // next state of all register-bank bits
    always_comb begin
        lamp_q_hold: begin
            lamp_d     = lamp_q;
            lamp_rsv_d = lamp_rsv_q;
        end
        run_d = run_q;
        flink_d = flink_q;
        drsv_d = drsv_q;
        nloop_d = nloop_q;
        short_d = short_q;
        res_d = res_q;
        cnt_d = cnt_q;
        mode_d = mode_q;
        eee_d = eee_q;
        sp0_d = sp0_q;
        ad9_d = ad9_q;
        if (wr_lamp) begin
            lamp_d     = reg_wdata[ppc_pkg::LAMP_HI:ppc_pkg::LAMP_LO];
            lamp_rsv_d = reg_wdata[11:0];
        end
        if (wr_diag) begin
            flink_d = reg_wdata[ppc_pkg::DG_FLINK];
            drsv_d  = reg_wdata[ppc_pkg::DG_RSV];
            nloop_d = reg_wdata[ppc_pkg::DG_NLOOP];
        end
        if (wr_spec) begin
            flink_d = reg_wdata[ppc_pkg::SP_FLINK];
            nloop_d = reg_wdata[ppc_pkg::SP_NLOOP];
            eee_d   = reg_wdata[ppc_pkg::SP_EEE];
            sp0_d   = reg_wdata[ppc_pkg::SP_RSV0];
        end
        // completion first, so a fresh start in the same cycle still wins
        if (run_q && diag_done) begin
            run_d   = 1'b0;
            res_d   = diag_result;
            short_d = diag_short_near && (diag_result != ppc_pkg::RES_FAIL);
            cnt_d   = diag_fault_count;
        end
        if (start_req) begin
            run_d = 1'b1;
        end
        if (wr_mode) begin
            mode_d = reg_wdata;
        end
        if (wr_basic) begin
            mode_d[ppc_pkg::MD_FLOOP]   = reg_wdata[ppc_pkg::BC_LOOP];
            mode_d[ppc_pkg::MD_SPD]     = reg_wdata[ppc_pkg::BC_SPD];
            mode_d[ppc_pkg::MD_ANEN]    = reg_wdata[ppc_pkg::BC_ANEN];
            mode_d[ppc_pkg::MD_PDN]     = reg_wdata[ppc_pkg::BC_PDN];
            mode_d[ppc_pkg::MD_RESTART] = reg_wdata[ppc_pkg::BC_RESTART];
            mode_d[ppc_pkg::MD_DPX]     = reg_wdata[ppc_pkg::BC_DPX];
            mode_d[ppc_pkg::MD_FMDIX]   = reg_wdata[ppc_pkg::BC_FMDIX];
            mode_d[ppc_pkg::MD_NOAMDIX] = reg_wdata[ppc_pkg::BC_NOAMDIX];
            mode_d[ppc_pkg::MD_NOFEF]   = reg_wdata[ppc_pkg::BC_NOFEF];
            mode_d[ppc_pkg::MD_TXDIS]   = reg_wdata[ppc_pkg::BC_TXDIS];
        end
        if (wr_adv) begin
            mode_d[4] = reg_wdata[ppc_pkg::AD_PAUSE];
            mode_d[3] = reg_wdata[ppc_pkg::AD_100F];
            mode_d[2] = reg_wdata[ppc_pkg::AD_100H];
            mode_d[1] = reg_wdata[ppc_pkg::AD_10F];
            mode_d[0] = reg_wdata[ppc_pkg::AD_10H];
            ad9_d     = reg_wdata[ppc_pkg::AD_RSV9];
        end
        // restart clears once the phy takes it, unless rewritten now
        if (mode_q[ppc_pkg::MD_RESTART] && neg_restart_ack && !(wr_mode && reg_wdata[ppc_pkg::MD_RESTART])
            && !(wr_basic && reg_wdata[ppc_pkg::BC_RESTART])) begin
            mode_d[ppc_pkg::MD_RESTART] = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lamp_q <= 3'h0;
            lamp_rsv_q <= ppc_pkg::LAMP_RSV_RST;
            run_q <= 1'b0;
            flink_q <= 1'b0;
            drsv_q <= 1'b1;
            nloop_q <= 1'b0;
            short_q <= 1'b0;
            res_q <= 2'h0;
            cnt_q <= 9'h000;
            mode_q <= ppc_pkg::MODE_RST;
            eee_q <= 1'b1;
            sp0_q <= 1'b0;
            ad9_q <= 1'b0;
        end else if (clk_en) begin
            lamp_q <= lamp_d;
            lamp_rsv_q <= lamp_rsv_d;
            run_q <= run_d;
            flink_q <= flink_d;
            drsv_q <= drsv_d;
            nloop_q <= nloop_d;
            short_q <= short_d;
            res_q <= res_d;
            cnt_q <= cnt_d;
            mode_q <= mode_d;
            eee_q <= eee_d;
            sp0_q <= sp0_d;
            ad9_q <= ad9_d;
        end
    end

    // link pin synchroniser, three stages; level moves only when the last two agree
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lnk_sync_q <= 3'h0;
            lnk_level_q <= 1'b0;
        end else if (clk_en) begin
            lnk_sync_q <= {lnk_sync_q[1:0], link_pin};
            lnk_level_q <= lnk_level_d;
        end
    end

    // read data and derived phy controls
    always_comb begin
        rd_mux = 16'h0000;
        unique case (reg_addr)
            ppc_pkg::OFS_LAMP: rd_mux = {1'b0, lamp_q, lamp_rsv_q};
            ppc_pkg::OFS_DIAG: rd_mux = {short_q, res_q, run_q, flink_q, drsv_q, nloop_q, cnt_q};
            ppc_pkg::OFS_MODE: rd_mux = mode_q;
            ppc_pkg::OFS_SPEC: rd_mux = {12'h000, flink_q, eee_q, nloop_q, sp0_q};
            ppc_pkg::OFS_BASIC: rd_mux = {1'b0, mode_q[ppc_pkg::MD_FLOOP], mode_q[ppc_pkg::MD_SPD],
                mode_q[ppc_pkg::MD_ANEN], mode_q[ppc_pkg::MD_PDN], 1'b0, mode_q[ppc_pkg::MD_RESTART],
                mode_q[ppc_pkg::MD_DPX], 3'h0, mode_q[ppc_pkg::MD_FMDIX], mode_q[ppc_pkg::MD_NOAMDIX],
                mode_q[ppc_pkg::MD_NOFEF], mode_q[ppc_pkg::MD_TXDIS], 1'b0};
            ppc_pkg::OFS_ADV: rd_mux = {5'h00, mode_q[4], ad9_q, mode_q[3:0], ppc_pkg::AD_SELECTOR};
            default: rd_mux = 16'h0000;
        endcase
        rd_d = reg_rd ? rd_mux : reg_rdata;
        // a one-cycle glitch on the pin never reaches the lamps
        lnk_level_d = (lnk_sync_q[2] == lnk_sync_q[1]) ? lnk_sync_q[2] : lnk_level_q;
        link_d = flink_q || lnk_level_q;
        lamp0_d = lamp_q[2] ? lamp_q[0] : link_d;
        lamp1_d = lamp_q[2] ? lamp_q[1] : (link_d && speed_100);
        dpx_d = mode_q[ppc_pkg::MD_ANEN] ? (neg_done && neg_ok) : mode_q[ppc_pkg::MD_DPX];
    end

    // registered outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
            port_lamp_0 <= 1'b0;
            port_lamp_1 <= 1'b0;
            lamp_override <= 1'b0;
            diag_start <= 1'b0;
            force_link <= 1'b0;
            near_loop <= 1'b0;
            tx_disable <= 1'b0;
            neg_restart <= 1'b0;
            fef_disable <= 1'b0;
            power_down <= 1'b0;
            mdix_auto <= 1'b1;
            mdix_force <= 1'b0;
            far_loop <= 1'b0;
            neg_enable <= 1'b1;
            speed_100 <= 1'b1;
            full_duplex <= 1'b0;
            advert <= 5'h1f;
            link_up <= 1'b0;
        end else if (clk_en) begin
            reg_rdata <= rd_d;
            reg_rvalid <= reg_rd;
            port_lamp_0 <= lamp0_d;
            port_lamp_1 <= lamp1_d;
            lamp_override <= lamp_q[2];
            diag_start <= run_q;
            force_link <= flink_q;
            near_loop <= nloop_q;
            tx_disable <= mode_q[ppc_pkg::MD_TXDIS];
            neg_restart <= mode_q[ppc_pkg::MD_RESTART];
            fef_disable <= mode_q[ppc_pkg::MD_NOFEF];
            power_down <= mode_q[ppc_pkg::MD_PDN];
            mdix_auto <= !mode_q[ppc_pkg::MD_NOAMDIX];
            mdix_force <= mode_q[ppc_pkg::MD_NOAMDIX] && mode_q[ppc_pkg::MD_FMDIX];
            far_loop <= mode_q[ppc_pkg::MD_FLOOP];
            neg_enable <= mode_q[ppc_pkg::MD_ANEN];
            speed_100 <= mode_q[ppc_pkg::MD_SPD];
            full_duplex <= dpx_d;
            advert <= mode_q[4:0];
            link_up <= link_d;
        end
    end

    // checks
    chk_start_sets: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && start_req |=> run_q)
        else $error("diag start not taken");
    chk_done_clears: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && run_q && diag_done && !start_req |=> !run_q && res_q == $past(diag_result))
        else $error("diag not cleared");
    chk_lamp_force: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && lamp_q == 3'h5 |=> port_lamp_0 && !port_lamp_1)
        else $error("lamp override wrong");
    chk_mdix_force: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !mode_q[ppc_pkg::MD_NOAMDIX] |=> !mdix_force && mdix_auto)
        else $error("mdix forced wrongly");
    chk_mirror_flink: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && wr_spec && !wr_diag |=> flink_q == $past(reg_wdata[ppc_pkg::SP_FLINK]))
        else $error("mirror lost");
    chk_adv_mirror: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && wr_adv && !wr_mode |=> mode_q[4] == $past(reg_wdata[ppc_pkg::AD_PAUSE]))
        else $error("advert mirror lost");
    chk_half_fail: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && mode_q[ppc_pkg::MD_ANEN] && !neg_ok |=> !full_duplex)
        else $error("failed neg not half");
    chk_pdn_keeps: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && power_down && !reg_wr && !neg_restart_ack |=> $stable(mode_q))
        else $error("power down changed regs");
    chk_restart_sc: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && mode_q[ppc_pkg::MD_RESTART] && neg_restart_ack && !reg_wr |=> !mode_q[ppc_pkg::MD_RESTART])
        else $error("restart stuck");
    cov_diag_run: cover property (@(posedge sys_clk) disable iff (rst) start_req ##[1:20] (run_q && diag_done));
    cov_lamp_both: cover property (@(posedge sys_clk) disable iff (rst) lamp_q == 3'h7);
    cov_forced: cover property (@(posedge sys_clk) disable iff (rst) !mode_q[ppc_pkg::MD_ANEN] && full_duplex);
endmodule
`default_nettype wire

// file: testbench/port_phy_control_regs_tb_top.sv
// Purpose: self-checking bench for the port phy control register bank
// Assumes: clk_en high except in the freeze case, phy core side and link pin driven by hand
// Notes:   reset first, then table rows, diagnostic, mirror and restart cases
`timescale 1ns/1ps
`default_nettype none
module port_phy_control_regs_tb_top;
    typedef struct {
        logic [11:0] a;
        logic [15:0] d;
        logic [15:0] rb;
        logic [18:0] o;
        logic [18:0] m;
    } ppc_tb_row_s;

    logic        sys_clk, rst, clk_en, reg_wr, reg_rd, diag_done, diag_short_near;
    logic        neg_done, neg_ok, link_pin, neg_restart_ack;
    logic [11:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, ro_bits;
    logic        reg_rvalid, port_lamp_0, port_lamp_1, lamp_override, diag_start, force_link;
    logic        near_loop, tx_disable, neg_restart, fef_disable, power_down, mdix_auto;
    logic        mdix_force, far_loop, neg_enable, speed_100, full_duplex, link_up;
    logic [1:0]  diag_result;
    logic [8:0]  diag_fault_count;
    logic [4:0]  advert;
    int          bad_count, checked;
    ppc_tb_row_s rows [10];

    ppc_regs i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .diag_done(diag_done), .diag_result(diag_result), .diag_short_near(diag_short_near),
        .diag_fault_count(diag_fault_count), .neg_done(neg_done), .neg_ok(neg_ok), .link_pin(link_pin),
        .neg_restart_ack(neg_restart_ack), .port_lamp_0(port_lamp_0), .port_lamp_1(port_lamp_1),
        .lamp_override(lamp_override), .diag_start(diag_start), .force_link(force_link),
        .near_loop(near_loop), .tx_disable(tx_disable), .neg_restart(neg_restart), .fef_disable(fef_disable),
        .power_down(power_down), .mdix_auto(mdix_auto), .mdix_force(mdix_force), .far_loop(far_loop),
        .neg_enable(neg_enable), .speed_100(speed_100), .full_duplex(full_duplex), .advert(advert),
        .link_up(link_up));

    // free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // prints the counts and the verdict, then stops
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [18:0] e, input logic [18:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // controlled outputs except diag_start, neg_restart and link_up packed into one word, lamps on top
    function automatic logic [18:0] outs();
        return {lamp_override, port_lamp_1, port_lamp_0, force_link, near_loop, tx_disable, fef_disable,
                power_down, mdix_auto, mdix_force, far_loop, neg_enable, speed_100, full_duplex, advert};
    endfunction

    // write strobe held over one edge, then one idle cycle so strobes never collide
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk); #1;
        reg_wr = 1'b0;
        @(posedge sys_clk); #1;
    endtask

    // read with a bounded wait for the answer
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        int n;
        n = 0;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk); #1;
        reg_rd = 1'b0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge sys_clk); #1;
            n++;
        end
        if (n == 4) begin
            bad_count++;
            $display("wrong value rvalid expected 1 seen %b", reg_rvalid);
            final_report();
        end else begin
            cmp("rdata", {3'h0, e}, {3'h0, reg_rdata});
            @(posedge sys_clk); #1;
        end
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        $display("wrong value watchdog expected done seen running");
        final_report();
    end

    // main sequence
    initial begin
        {rst, clk_en, reg_wr, reg_rd, diag_done, diag_short_near} = 6'b110000;
        {neg_done, neg_ok, link_pin, neg_restart_ack} = 4'h0;
        {reg_addr, reg_wdata, diag_result, diag_fault_count} = '0;
        bad_count = 0;
        checked = 0;
        ro_bits = 16'h0000;
        rows = '{
            '{ppc_pkg::OFS_LAMP, 16'h3abc, 16'h3abc, 19'h0049f, 19'h7ff9f},
            '{ppc_pkg::OFS_LAMP, 16'h4000, 16'h4000, 19'h4049f, 19'h7ff9f},
            '{ppc_pkg::OFS_LAMP, 16'h5000, 16'h5000, 19'h5049f, 19'h7ff9f},
            '{ppc_pkg::OFS_LAMP, 16'h6000, 16'h6000, 19'h6049f, 19'h7ff9f},
            '{ppc_pkg::OFS_LAMP, 16'hf000, 16'h7000, 19'h7049f, 19'h7ff9f},
            '{ppc_pkg::OFS_DIAG, 16'h0a00, 16'h0a00, 19'h7c49f, 19'h7ff9f},
            '{ppc_pkg::OFS_MODE, 16'h5f00, 16'h5f00, 19'h7fb00, 19'h7ffff},
            '{ppc_pkg::OFS_MODE, 16'h8060, 16'h8060, 19'h7c460, 19'h7ffff},
            '{ppc_pkg::OFS_MODE, 16'h0215, 16'h0215, 19'h7c415, 19'h7ffff},
            '{ppc_pkg::OFS_DIAG, 16'h0400, 16'h0400, 19'h70415, 19'h7ffff}
        };
        repeat (10) @(posedge sys_clk);
        #1;
        cmp("reset outputs", 19'h004df, outs());
        rst = 1'b0;
        @(posedge sys_clk); #1;
        rd(ppc_pkg::OFS_LAMP, 16'h0000);
        rd(ppc_pkg::OFS_DIAG, 16'h0400);
        rd(ppc_pkg::OFS_MODE, 16'h00ff);
        // table rows: write, let outputs settle two cycles, compare, read back
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            @(posedge sys_clk); #1;
            cmp("outputs", rows[i].o & rows[i].m, outs() & rows[i].m);
            rd(rows[i].a, rows[i].rb);
        end
        // every diagnostic result code, start then completion
        for (int r = 0; r < 4; r++) begin
            wr(ppc_pkg::OFS_DIAG, 16'h1400);
            @(posedge sys_clk); #1;
            cmp("diag_start", 19'h1, {18'h0, diag_start});
            rd(ppc_pkg::OFS_DIAG, ro_bits | 16'h1400);
            diag_result = 2'(r);
            diag_short_near = r[0];
            diag_fault_count = 9'h100 + 9'(r);
            diag_done = 1'b1;
            @(posedge sys_clk); #1;
            diag_done = 1'b0;
            @(posedge sys_clk); #1;
            // a failed test reports no near short
            ro_bits = {r[0] && (r != 3), 2'(r), 4'h0, 9'h100 + 9'(r)};
            rd(ppc_pkg::OFS_DIAG, ro_bits | 16'h0400);
            cmp("diag_start", 19'h0, {18'h0, diag_start});
        end
        // read-only diagnostic fields ignore writes
        wr(ppc_pkg::OFS_DIAG, 16'he5ff);
        rd(ppc_pkg::OFS_DIAG, ro_bits | 16'h0400);
        // mirrored bits written through the other address
        wr(ppc_pkg::OFS_SPEC, 16'h000a);
        rd(ppc_pkg::OFS_DIAG, ro_bits | 16'h0e00);
        cmp("force_link", 19'h1, {18'h0, force_link});
        wr(ppc_pkg::OFS_ADV, 16'h0421);
        rd(ppc_pkg::OFS_MODE, 16'h0211);
        rd(ppc_pkg::OFS_ADV, 16'h0421);
        // restart request clears itself once the phy takes it
        wr(ppc_pkg::OFS_MODE, 16'h2211);
        cmp("neg_restart", 19'h1, {18'h0, neg_restart});
        neg_restart_ack = 1'b1;
        @(posedge sys_clk); #1;
        neg_restart_ack = 1'b0;
        @(posedge sys_clk); #1;
        rd(ppc_pkg::OFS_MODE, 16'h0211);
        cmp("neg_restart", 19'h0, {18'h0, neg_restart});
        // failed negotiation falls back to half duplex
        wr(ppc_pkg::OFS_MODE, 16'h00ff);
        {neg_done, neg_ok} = 2'b10;
        repeat (3) @(posedge sys_clk);
        #1;
        cmp("full_duplex", 19'h0, {18'h0, full_duplex});
        // unmapped places read zero and drop writes
        wr(12'h060, 16'hffff);
        rd(12'h060, 16'h0000);
        rd(12'h070, 16'h0000);
        // second reset in mid-run restores defaults
        rst = 1'b1;
        @(posedge sys_clk); #1;
        rst = 1'b0;
        @(posedge sys_clk); #1;
        rd(ppc_pkg::OFS_MODE, 16'h00ff);
        rd(ppc_pkg::OFS_LAMP, 16'h0000);
        // link pin drives the lamps in normal mode, a one-cycle drop is filtered
        link_pin = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        cmp("link_up", 19'h1, {18'h0, link_up});
        cmp("lamps", 19'h3, {17'h0, port_lamp_1, port_lamp_0});
        link_pin = 1'b0;
        @(posedge sys_clk); #1;
        link_pin = 1'b1;
        repeat (6) begin
            @(posedge sys_clk); #1;
            cmp("link_up", 19'h1, {18'h0, link_up});
        end
        link_pin = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        cmp("link_up", 19'h0, {18'h0, link_up});
        cmp("lamps", 19'h0, {17'h0, port_lamp_1, port_lamp_0});
        // a write while the clock enable is low is not taken
        clk_en = 1'b0;
        wr(ppc_pkg::OFS_LAMP, 16'h7000);
        clk_en = 1'b1;
        rd(ppc_pkg::OFS_LAMP, 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
